// [hdl/reset_source_controller.sv]
// Reset source controller: gathers reset requests, holds system reset, records the cause
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
module reset_source_controller
  import reset_source_pkg::*;
#(
  parameter int unsigned HOLD   = HOLD_CYCLES,   // Reset hold length in cycles
  parameter int unsigned ADDR_W = 16             // Flash address width
) (
  input  wire logic              I_REF_CLK,          // 25 MHz clock
  input  wire logic              I_NRST,             // Power-on reset, sync, low
  input  wire logic              I_HSEL,             // AHB select
  input  wire logic [31:0]       I_HADDR,            // AHB address
  input  wire logic [1:0]        I_HTRANS,           // AHB transfer type
  input  wire logic              I_HWRITE,           // AHB write
  input  wire logic [2:0]        I_HSIZE,            // AHB size (word only)
  input  wire logic [31:0]       I_HWDATA,           // AHB write data
  input  wire logic              I_HREADY,           // AHB bus ready
  output logic [31:0]            O_HRDATA,           // AHB read data
  output logic                   O_HREADYOUT,        // AHB slave ready
  output logic                   O_HRESP,            // AHB response
  input  wire logic              I_RST_PIN_N,        // External reset pin level
  input  wire logic              I_CMP0_OUT,         // Comparator 0 output
  input  wire logic              I_CMP0_WAKE_EN,     // Comparator 0 is wake source
  input  wire logic              I_LOW_POWER,        // Suspend or sleep state
  input  wire logic              I_WDOG_OVERFLOW,    // Counter array watchdog overflow
  input  wire logic              I_FLASH_WR,         // Flash write or erase attempt
  input  wire logic              I_FLASH_WE,         // flash_write_enable
  input  wire logic              I_CODE_READ,        // code_space_read access
  input  wire logic              I_FETCH,            // Instruction fetch
  input  wire logic [ADDR_W-1:0] I_FLASH_ADDR,       // Flash access address
  input  wire logic [ADDR_W-1:0] I_LOCK_ADDR,        // Lock byte address
  input  wire logic              I_FLASH_SEC_BLOCK,  // Access refused by security
  input  wire logic              I_SUPPLY_MON_ON,    // Supply monitor powered
  input  wire logic              I_SUPPLY_LOW,       // Supply monitor trip
  input  wire logic              I_SYSTEM_CLOCK_MON,       // Monitored system clock
  input  wire logic              I_RTC_MCD_EN,       // Clock osc detector enabled
  input  wire logic              I_RTC_CLK_SLOW,     // Clock osc below 20 kHz
  input  wire logic              I_RTC_ALARM_EN,     // Alarm enabled
  input  wire logic [31:0]       I_RTC_TIMER,        // Clock timer value
  input  wire logic [31:0]       I_RTC_ALARM_VALUE,  // alarm_match_regs contents
  output logic                   O_SYS_RST_N,        // System reset, low active
  output logic                   O_WDOG_ENABLE,      // Pulse: watchdog on at release
  output logic                   O_WDOG_TICK         // Watchdog clock enable pulse
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int unsigned SYNC_W = 5;
  localparam int unsigned S_PIN  = 0;
  localparam int unsigned S_CMP  = 1;
  localparam int unsigned S_SUP  = 2;
  localparam int unsigned S_CLK  = 3;
  localparam int unsigned S_RTC  = 4;

  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_s1;
  logic [SYNC_W-1:0] sync_s2;
  logic [SYNC_W-1:0] sync_s3;
  logic [SYNC_W-1:0] sync_f;

  assign sync_raw = {I_RTC_CLK_SLOW, I_SYSTEM_CLOCK_MON, I_SUPPLY_LOW, I_CMP0_OUT, I_RST_PIN_N};

  // A change counts only once the second and third stages agree
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_sync
      always_ff @(posedge I_REF_CLK) begin
        if (!I_NRST) begin
          sync_s1[g] <= SYNC_IDLE[g];
          sync_s2[g] <= SYNC_IDLE[g];
          sync_s3[g] <= SYNC_IDLE[g];
          sync_f[g]  <= SYNC_IDLE[g];
        end else begin
          sync_s1[g] <= sync_raw[g];
          sync_s2[g] <= sync_s1[g];
          sync_s3[g] <= sync_s2[g];
          if (sync_s2[g] == sync_s3[g]) begin
            sync_f[g] <= sync_s3[g];
          end
        end
      end
    end
  endgenerate

  wire pin_low   = !sync_f[S_PIN];
  wire cmp_out   = sync_f[S_CMP];
  wire sup_low   = sync_f[S_SUP];
  wire clk_mon   = sync_f[S_CLK];
  wire rtc_slow  = sync_f[S_RTC];

  // ****************************************
  // State and register storage
  // ****************************************
  seq_state_e        state;
  logic [7:0]        flags;
  logic              cmp_en;
  logic              rtc_en;
  logic              mcd_en;
  logic              sup_en;
  localparam int unsigned HOLD_W = $clog2(HOLD + 1);
  localparam int unsigned MCD_W  = $clog2(MCD_CYCLES + 1);
  localparam int unsigned DIV_W  = $clog2(WDOG_DIV);
  logic [HOLD_W-1:0] hold_cnt;
  logic [MCD_W-1:0]  mcd_cnt;
  logic [DIV_W-1:0]  div_cnt;
  logic              clk_mon_d;

  // ****************************************
  // AHB-Lite slave decode
  // ****************************************
  logic wr_pend;
  logic rd_hit_now;
  wire  addr_phase = I_HSEL && I_HTRANS[1] && I_HREADY;
  wire  addr_hit   = (I_HADDR == RSF_ADDR);
  wire  wr_hit     = wr_pend && (state == ST_RUN);
  assign rd_hit_now = addr_phase && !I_HWRITE && addr_hit;

  // Zero wait states; unmapped reads give zero, unmapped writes drop
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      wr_pend  <= 1'b0;
      O_HRDATA <= 32'h0;
    end else begin
      wr_pend  <= addr_phase && I_HWRITE && addr_hit;
      O_HRDATA <= rd_hit_now ? {24'h0, flags} : 32'h0;
    end
  end

  // ****************************************
  // Reset requests
  // ****************************************
  logic [NUM_SRC-1:0] req;
  logic [NUM_SRC-1:0] pick;

  wire above_lock = (I_FLASH_ADDR > I_LOCK_ADDR);
  wire flash_err  = (I_FLASH_WR && I_FLASH_WE && above_lock)
                 || ((I_CODE_READ || I_FETCH) && above_lock)
                 || I_FLASH_SEC_BLOCK
                 || (I_FLASH_WR && I_FLASH_WE && !I_SUPPLY_MON_ON);
  wire rtc_alarm  = I_RTC_ALARM_EN && (I_RTC_TIMER == I_RTC_ALARM_VALUE);
  wire rtc_fail   = I_RTC_MCD_EN && rtc_slow;
  wire cmp_live   = !I_LOW_POWER || I_CMP0_WAKE_EN;
  wire mcd_hit    = (mcd_cnt == MCD_W'(MCD_CYCLES));

  // Internal sources only drop O_SYS_RST_N; the pin is input only
  assign req[BIT_RTC]   = rtc_en && (rtc_alarm || rtc_fail);
  assign req[BIT_FLASH] = flash_err;
  assign req[BIT_CMP]   = cmp_en && !cmp_out && cmp_live;
  assign req[BIT_SW]    = wr_hit && I_HWDATA[BIT_SW];
  assign req[BIT_WDOG]  = I_WDOG_OVERFLOW && !I_LOW_POWER;
  assign req[BIT_MCD]   = mcd_en && !I_LOW_POWER && mcd_hit;
  // Selecting the monitor while the supply is still low resets at once
  assign req[BIT_SUP]   = sup_en && sup_low;
  assign req[BIT_PIN]   = pin_low;

  // Supply wins, then the lowest bit; exactly one cause is recorded
  assign pick = req[BIT_SUP] ? FLAG_SUP_ONE : (req & (~req + NUM_SRC'(1)));

  wire hold_done  = (hold_cnt >= HOLD_W'(HOLD - 1));
  wire hold_stays = pin_low || (sup_en && sup_low);

  // ****************************************
  // Reset sequencer
  // ****************************************
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      state    <= ST_HOLD;
      flags    <= FLAGS_POR;
      hold_cnt <= '0;
      cmp_en   <= 1'b0;
      rtc_en   <= 1'b0;
      mcd_en   <= 1'b0;
      sup_en   <= 1'b1;
    end else begin
      case (state)
        ST_RUN: begin
          if (|req) begin
            state    <= ST_HOLD;
            flags    <= pick;
            hold_cnt <= '0;
            // Enables drop with the reset; the supply selection survives
            cmp_en   <= 1'b0;
            rtc_en   <= 1'b0;
            mcd_en   <= 1'b0;
          end else if (wr_hit) begin
            cmp_en <= I_HWDATA[BIT_CMP];
            rtc_en <= I_HWDATA[BIT_RTC];
            mcd_en <= I_HWDATA[BIT_MCD];
            sup_en <= I_HWDATA[BIT_SUP];
          end
        end
        ST_HOLD: begin
          if (!hold_done) begin
            hold_cnt <= hold_cnt + HOLD_W'(1);
          end else if (!hold_stays) begin
            state <= ST_RUN;
          end
        end
        default: begin
          state <= ST_HOLD;
        end
      endcase
    end
  end

  // ****************************************
  // Missing clock detector
  // ****************************************
  // The count restarts on each edge of the monitored clock
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      clk_mon_d <= 1'b0;
      mcd_cnt   <= '0;
    end else begin
      clk_mon_d <= clk_mon;
      if ((clk_mon != clk_mon_d) || !mcd_en || I_LOW_POWER || (state != ST_RUN)) begin
        mcd_cnt <= '0;
      end else if (!mcd_hit) begin
        mcd_cnt <= mcd_cnt + MCD_W'(1);
      end
    end
  end

  // ****************************************
  // Watchdog clock and enable
  // ****************************************
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      div_cnt       <= '0;
      O_WDOG_TICK   <= 1'b0;
      O_WDOG_ENABLE <= 1'b0;
      O_SYS_RST_N   <= 1'b0;
    end else begin
      O_SYS_RST_N   <= (state == ST_RUN) && !(|req);
      // Pulse rises together with the release, not one cycle ahead of it
      O_WDOG_ENABLE <= (state == ST_RUN) && !(|req) && !O_SYS_RST_N;
      // Divider restarts with every reset so the tick phase is known
      if (state != ST_RUN) begin
        div_cnt     <= '0;
        O_WDOG_TICK <= 1'b0;
      end else if (div_cnt == DIV_W'(WDOG_DIV - 1)) begin
        div_cnt     <= '0;
        O_WDOG_TICK <= 1'b1;
      end else begin
        div_cnt     <= div_cnt + DIV_W'(1);
        O_WDOG_TICK <= 1'b0;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);

  cmp_enable_a: assert property (
    (state == ST_RUN && wr_hit && !(|req)) |=> (cmp_en == $past(I_HWDATA[BIT_CMP])))
    else $error("comparator enable not taken from write");

  cmp_reset_a: assert property (
    (state == ST_RUN && cmp_en && !cmp_out && !I_LOW_POWER) |=> !O_SYS_RST_N)
    else $error("comparator low did not reset");

  cmp_flag_a: assert property (
    (state == ST_RUN && pick[BIT_CMP]) |=> flags[BIT_CMP] && $onehot(flags))
    else $error("comparator flag wrong after reset");

  cmp_sleep_a: assert property (
    (I_LOW_POWER && !I_CMP0_WAKE_EN) |-> !req[BIT_CMP])
    else $error("comparator reset while not a wake source");

  wdog_release_a: assert property (
    $rose(O_SYS_RST_N) |-> O_WDOG_ENABLE ##1 (!O_WDOG_TICK [*8]))
    else $error("watchdog not enabled at release");

  wdog_tick_a: assert property (
    O_WDOG_TICK |=> (!O_WDOG_TICK [*8]))
    else $error("watchdog tick too frequent");

  wdog_sleep_a: assert property (
    I_LOW_POWER |-> !req[BIT_WDOG] && !req[BIT_MCD])
    else $error("watchdog or detector reset in low power");

  sw_reset_a: assert property (
    (state == ST_RUN && wr_hit && I_HWDATA[BIT_SW])
      |=> !O_SYS_RST_N && (flags[BIT_SW] || flags[BIT_SUP] || flags[BIT_PIN]))
    else $error("software force did not reset");

  hold_len_a: assert property (
    $fell(O_SYS_RST_N) |-> (!O_SYS_RST_N [*8]) ##0 $onehot(flags))
    else $error("reset hold too short or cause not single");

  mcd_bound_a: assert property (
    (mcd_cnt == MCD_W'(MCD_CYCLES) && mcd_en && !I_LOW_POWER && state == ST_RUN)
      |=> !O_SYS_RST_N)
    else $error("detector timeout did not reset");

  flash_err_a: assert property (
    (state == ST_RUN && flash_err) |=> !O_SYS_RST_N)
    else $error("flash error did not reset");

  rtc_reset_a: assert property (
    (state == ST_RUN && rtc_en && (rtc_alarm || rtc_fail)) |=> !O_SYS_RST_N)
    else $error("clock event did not reset");

  cover_sw_c:   cover property (state == ST_RUN && pick[BIT_SW]);
  cover_cmp_c:  cover property (state == ST_RUN && pick[BIT_CMP]);
  cover_pin_c:  cover property (state == ST_RUN && pick[BIT_PIN]);
  cover_mcd_c:  cover property (state == ST_RUN && pick[BIT_MCD]);
  cover_wdog_c: cover property (state == ST_RUN && pick[BIT_WDOG]);

endmodule

// [shared/reset_source_pkg.sv]
// Shared constants for the reset source controller
package reset_source_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  RSF_INDEX = 8'hef;
  // The printed offset is a register index; the bus sees four bytes per index
  localparam logic [31:0] RSF_ADDR  = {22'h0, RSF_INDEX, 2'b00};

  // ****************************************
  // Bit positions of reset_source_flags
  // ****************************************
  localparam int unsigned BIT_PIN   = 0;
  localparam int unsigned BIT_SUP   = 1;
  localparam int unsigned BIT_MCD   = 2;
  localparam int unsigned BIT_WDOG  = 3;
  localparam int unsigned BIT_SW    = 4;
  localparam int unsigned BIT_CMP   = 5;
  localparam int unsigned BIT_FLASH = 6;
  localparam int unsigned BIT_RTC   = 7;
  localparam int unsigned NUM_SRC   = 8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  FLAGS_POR    = 8'h02;
  localparam logic [7:0]  FLAGS_NONE   = 8'h00;
  localparam logic [7:0]  FLAG_SUP_ONE = 8'h02;
  // Pin and comparator idle high, other synchronised inputs idle low
  localparam logic [4:0]  SYNC_IDLE    = 5'h03;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned MCD_TIME_NS   = 100000;
  // Least time: rounded up to whole cycles
  localparam int unsigned MCD_CYCLES    = (MCD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WDOG_DIV      = 12;
  localparam int unsigned HOLD_CYCLES   = 16;

  typedef enum logic [0:0] {
    ST_RUN,
    ST_HOLD
  } seq_state_e;

endpackage

// [testbench/reset_source_controller_tb.sv]
// Self-checking testbench for the reset source controller
`timescale 1ns/1ps
module reset_source_controller_tb;
  import reset_source_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic        clk, nrst, hsel, hwrite, pin_n, cmp, wake, lp, wovf, fwr, fwe;
  logic        cread, fetch, sec, smon, sup_low, mon, mcd_en, slow, alarm_en, mcd_stop;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, timer, rdat;
  logic [15:0] faddr;
  logic [1:0]  mdiv;
  wire  [31:0] hrdata;
  wire         hready, hresp, sys_rst_n, wdog_en, wtick;
  int          fail_count, n_tests;

  reset_source_controller #(.HOLD(16), .ADDR_W(16)) dut_u (
    .I_REF_CLK(clk), .I_NRST(nrst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_RST_PIN_N(pin_n),
    .I_CMP0_OUT(cmp), .I_CMP0_WAKE_EN(wake), .I_LOW_POWER(lp), .I_WDOG_OVERFLOW(wovf),
    .I_FLASH_WR(fwr), .I_FLASH_WE(fwe), .I_CODE_READ(cread), .I_FETCH(fetch),
    .I_FLASH_ADDR(faddr), .I_LOCK_ADDR(16'h7fff), .I_FLASH_SEC_BLOCK(sec),
    .I_SUPPLY_MON_ON(smon), .I_SUPPLY_LOW(sup_low), .I_SYSTEM_CLOCK_MON(mon),
    .I_RTC_MCD_EN(mcd_en), .I_RTC_CLK_SLOW(slow), .I_RTC_ALARM_EN(alarm_en),
    .I_RTC_TIMER(timer), .I_RTC_ALARM_VALUE(32'h0000_0005), .O_SYS_RST_N(sys_rst_n),
    .O_WDOG_ENABLE(wdog_en), .O_WDOG_TICK(wtick)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Monitored clock toggles every four cycles unless a scenario stalls it;
  // the input filter needs two equal samples, so a toggle every cycle never passes
  always @(posedge clk) begin
    if (!mcd_stop) begin
      mdiv <= mdiv + 2'h1;
      if (mdiv == 2'h3) mon <= ~mon;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic end_sim;
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic timeout(input string nm);
    $display("MISMATCH %s expected completion seen timeout", nm);
    fail_count++;
    end_sim;
  endtask

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic wait_ready;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hready !== 1'b1 && i < 50);
    if (hready !== 1'b1) timeout("hready");
  endtask

  // One single-word transfer; read data taken at the closing data-phase edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'b010;
    wait_ready;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready;
    rd = hrdata;
  endtask

  task automatic set_src(input int k, input logic v);
    case (k)
      0: pin_n <= ~v;
      1: cmp <= ~v;
      2: wovf <= v;
      3: fetch <= v;
      4: cread <= v;
      5: begin
        fwr <= v;
        fwe <= v;
      end
      6: sec <= v;
      7: begin
        fwr   <= v;
        fwe   <= v;
        smon  <= ~v;
        faddr <= v ? 16'h0100 : 16'h8000;
      end
      8: begin
        alarm_en <= v;
        timer    <= v ? 32'h0000_0005 : 32'h0;
      end
      9: begin
        mcd_en <= v;
        slow   <= v;
      end
      11: begin
        fetch <= v;
        faddr <= v ? 16'h0100 : 16'h8000;
      end
      12: mcd_stop <= v;
      13: sup_low <= v;
      default: ;
    endcase
  endtask

  task automatic no_reset(input int n);
    int lows;
    lows = 0;
    repeat (n) begin
      step;
      if (sys_rst_n !== 1'b1) lows++;
    end
    chk("cycles_in_reset", 0, lows);
  endtask

  // Reset must go low, release with the watchdog start pulse, then show one cause
  task automatic expect_reset(input int k, input logic [7:0] exp);
    int i;
    i = 0;
    while (sys_rst_n !== 1'b0 && i < 3000) begin
      step;
      i++;
    end
    if (sys_rst_n !== 1'b0) timeout("reset_entry");
    set_src(k, 1'b0);
    i = 0;
    while (sys_rst_n !== 1'b1 && i < 200) begin
      step;
      i++;
    end
    if (sys_rst_n !== 1'b1) timeout("reset_exit");
    chk("wdog_enable", 1, wdog_en);
    bus(1'b0, RSF_ADDR, 32'h0, rdat);
    chk("flags", {24'h0, exp}, rdat);
  endtask

  task automatic run_case(input int k, input logic [7:0] en, input logic lpw, input logic wk,
                          input logic [7:0] exp);
    bus(1'b1, RSF_ADDR, {24'h0, en}, rdat);
    lp   <= lpw;
    wake <= wk;
    @(posedge clk);
    set_src(k, 1'b1);
    if (exp !== 8'h00) expect_reset(k, exp);
    else begin
      no_reset((k == 12) ? 2700 : 12);
      set_src(k, 1'b0);
      // Let the withdrawn source pass the filter before low power ends
      repeat (8) @(posedge clk);
    end
    lp   <= 1'b0;
    wake <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int i;
    int n;
    {hsel, hwrite, wake, lp, wovf, fwr, fwe, cread, fetch, sec} = 10'h0;
    {sup_low, mon, mcd_en, slow, alarm_en, mcd_stop} = 6'h0;
    mdiv = 2'h0;
    {nrst, pin_n, cmp, smon} = 4'hf;
    nrst = 1'b0;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    timer = 32'h0;
    faddr = 16'h8000;
    fail_count = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    i = 0;
    while (sys_rst_n !== 1'b1 && i < 200) begin
      step;
      i++;
    end
    if (sys_rst_n !== 1'b1) timeout("por_exit");
    chk("hresp", 0, hresp);
    bus(1'b0, RSF_ADDR, 32'h0, rdat);
    chk("por_flags", {24'h0, FLAGS_POR}, rdat);
    i = 0;
    while (wtick !== 1'b1 && i < 40) begin
      step;
      i++;
    end
    n = 0;
    repeat (11) begin
      step;
      if (wtick === 1'b1) n++;
    end
    step;
    chk("tick_gap", 0, n);
    chk("tick_period", 1, wtick);
    bus(1'b1, RSF_ADDR, 32'h0000_004b, rdat);
    bus(1'b0, RSF_ADDR, 32'h0, rdat);
    chk("readonly_bits", {24'h0, FLAGS_POR}, rdat);
    // A forcing pattern at an unmapped place must do nothing
    bus(1'b1, 32'h0000_0000, 32'h0000_0010, rdat);
    no_reset(8);
    bus(1'b0, 32'h0000_0000, 32'h0, rdat);
    chk("unmapped_read", 0, rdat);
    run_case(10, 8'h12, 1'b0, 1'b0, 8'h10);
    run_case(0, 8'h02, 1'b0, 1'b0, 8'h01);
    run_case(1, 8'h02, 1'b0, 1'b0, 8'h00);
    run_case(1, 8'h22, 1'b0, 1'b0, 8'h20);
    run_case(1, 8'h22, 1'b1, 1'b0, 8'h00);
    run_case(1, 8'h22, 1'b1, 1'b1, 8'h20);
    run_case(2, 8'h02, 1'b1, 1'b0, 8'h00);
    run_case(2, 8'h02, 1'b0, 1'b0, 8'h08);
    run_case(3, 8'h02, 1'b0, 1'b0, 8'h40);
    run_case(4, 8'h02, 1'b0, 1'b0, 8'h40);
    run_case(5, 8'h02, 1'b0, 1'b0, 8'h40);
    run_case(11, 8'h02, 1'b0, 1'b0, 8'h00);
    run_case(6, 8'h02, 1'b0, 1'b0, 8'h40);
    run_case(7, 8'h02, 1'b0, 1'b0, 8'h40);
    run_case(8, 8'h02, 1'b0, 1'b0, 8'h00);
    run_case(8, 8'h82, 1'b0, 1'b0, 8'h80);
    run_case(9, 8'h82, 1'b1, 1'b0, 8'h80);
    run_case(12, 8'h06, 1'b1, 1'b0, 8'h00);
    run_case(12, 8'h06, 1'b0, 1'b0, 8'h04);
    run_case(13, 8'h00, 1'b0, 1'b0, 8'h00);
    run_case(13, 8'h02, 1'b0, 1'b0, 8'h02);
    end_sim;
  end

endmodule
